//--- hdl/i2c_target_front_end.sv
// I2C target front end: APB config registers, filters, hold delays
`default_nettype none
`include "ssi_params.svh"

module i2c_target_front_end (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output ssi_pkg::byte_t rx_data_o,
  output logic rx_valid_o,
  input wire ssi_pkg::byte_t tx_data_i,
  output logic tx_load_o,
  output ssi_pkg::byte_t spi_cfg_o,
  output logic addr_size_o,
  output logic crc_en_o,
  output ssi_pkg::byte_t pad_scl_cfg_o,
  output ssi_pkg::byte_t pad_sda_cfg_o,
  output ssi_pkg::byte_t pad_sdo_cfg_o,
  output ssi_pkg::byte_t pad_ncs_cfg_o
);
  import ssi_pkg::*;

  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------
  localparam byte_t CFG_RST [0:`NUM_CFG-1] = '{
    `RST_FLTR, `RST_TIMING, `RST_ADDR, `RST_SPI, `RST_GLOBAL,
    `RST_PAD_SCL, `RST_PAD_OTHER, `RST_PAD_OTHER, `RST_PAD_OTHER
  };
  localparam byte_t CFG_MASK [0:`NUM_CFG-1] = '{
    `MASK_FLTR, `MASK_TIMING, `MASK_ADDR, `MASK_SPI, `MASK_GLOBAL,
    `MASK_PAD_SCL, `MASK_PAD_OTHER, `MASK_PAD_OTHER, `MASK_PAD_OTHER
  };

  byte_t cfg_q [0:`NUM_CFG-1];
  logic [2:0] low_sel_q;
  logic [31:0] prdata_q;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  wire [31:0] addr_off = paddr_i - `SSI_BASE_ADDR;
  wire [3:0] reg_idx = addr_off[5:2];
  wire in_window = (addr_off[31:6] == 26'h000_0000) &&
                   (addr_off[1:0] == 2'h0);
  wire idx_known = (reg_idx <= `IDX_CRC) || (reg_idx == `IDX_LOW_SEL);
  wire reg_hit = in_window && idx_known;
  wire is_cfg = reg_idx <= `LAST_CFG;
  wire apb_setup = psel_i && !penable_i;
  wire apb_access = psel_i && penable_i;
  wire cfg_write = apb_access && pwrite_i && reg_hit && is_cfg;
  wire low_write = apb_access && pwrite_i && reg_hit &&
                   (reg_idx == `IDX_LOW_SEL);
  wire [7:0] wr_byte = pwdata_i[7:0];

  // ------------------------------------------------------------
  // Configuration fields
  // ------------------------------------------------------------
  wire [3:0] flt_len = cfg_q[`IDX_FLTR][`FLTR_LEN_MSB:`FLTR_LEN_LSB];
  wire [3:0] hold_high =
    cfg_q[`IDX_TIMING][`HOLD_HIGH_MSB:`HOLD_HIGH_LSB];
  wire [3:0] hold_low = cfg_q[`IDX_TIMING][`HOLD_LOW_MSB:`HOLD_LOW_LSB];
  wire [1:0] port_mode = cfg_q[`IDX_GLOBAL][`MODE_MSB:`MODE_LSB];
  wire i2c_on = port_mode == `MODE_I2C;
  wire [6:0] eff_addr = {
    cfg_q[`IDX_ADDR][`ADDR_UPPER_MSB:`ADDR_UPPER_LSB], low_sel_q
  };

  // ------------------------------------------------------------
  // Register write and read capture
  // ------------------------------------------------------------
  // Reserved bits keep their reset pattern; only masked bits take data.
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < `NUM_CFG; i++) begin
        cfg_q[i] <= CFG_RST[i];
      end
      low_sel_q <= `RST_LOW_SEL;
    end else begin
      if (cfg_write) begin
        cfg_q[reg_idx] <= (wr_byte & CFG_MASK[reg_idx]) |
                          (CFG_RST[reg_idx] & ~CFG_MASK[reg_idx]);
      end
      if (low_write) begin
        low_sel_q <= wr_byte[2:0];
      end
    end
  end

  i2c_state_t state_q;
  logic rw_q;
  wire busy = state_q != ST_IDLE;
  wire addressed = busy && (state_q != ST_ADDR) &&
                   (state_q != ST_WAIT_STOP);
  wire [7:0] event_byte = {5'h00, rw_q, addressed, busy};

  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (is_cfg) begin
      rd_byte = cfg_q[reg_idx];
    end else if (reg_idx == `IDX_EVENT) begin
      rd_byte = event_byte;
    end else if (reg_idx == `IDX_LOW_SEL) begin
      rd_byte = {5'h00, low_sel_q};
    end
  end

  // Read data is latched in the setup phase so it leaves a flop.
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      prdata_q <= 32'h0000_0000;
    end else if (apb_setup) begin
      prdata_q <= reg_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = 1'b1;
  assign pslverr_o = apb_access && !reg_hit;

  // ------------------------------------------------------------
  // Spike filters
  // ------------------------------------------------------------
  wire [1:0] raw_lines = {scl_i, sda_i};
  wire [1:0] filt_lines;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_filter
      logic [3:0] run_q;
      logic lvl_q;
      wire [3:0] run_inc = run_q + 4'h1;
      always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
          run_q <= 4'h0;
          lvl_q <= 1'b1;
        end else if (flt_len == 4'h0) begin
          run_q <= 4'h0;
          lvl_q <= raw_lines[g];
        end else if (raw_lines[g] == lvl_q) begin
          run_q <= 4'h0;
        end else if (run_inc >= flt_len) begin
          run_q <= 4'h0;
          lvl_q <= raw_lines[g];
        end else begin
          run_q <= run_inc;
        end
      end
      assign filt_lines[g] = lvl_q;
    end
  endgenerate

  wire scl_f = filt_lines[1];
  wire sda_f = filt_lines[0];

  // ------------------------------------------------------------
  // Bus condition detection
  // ------------------------------------------------------------
  logic scl_prev_q;
  logic sda_prev_q;
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_f;
      sda_prev_q <= sda_f;
    end
  end

  wire start_w = scl_f && scl_prev_q && sda_prev_q && !sda_f;
  wire stop_w = scl_f && scl_prev_q && !sda_prev_q && sda_f;
  wire scl_rise = scl_f && !scl_prev_q;
  wire scl_fall = !scl_f && scl_prev_q;

  // ------------------------------------------------------------
  // Target protocol engine
  // ------------------------------------------------------------
  logic [2:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic done_q;
  logic want_rel_q;
  byte_t rx_data_q;
  logic rx_valid_q;
  logic tx_load_q;

  wire [7:0] shift_in = {shift_q[6:0], sda_f};
  wire addr_match = shift_q[7:1] == eff_addr;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 3'h0;
      shift_q <= 8'h00;
      done_q <= 1'b0;
      want_rel_q <= 1'b1;
      rw_q <= 1'b0;
      rx_data_q <= 8'h00;
      rx_valid_q <= 1'b0;
      tx_load_q <= 1'b0;
    end else begin
      rx_valid_q <= 1'b0;
      tx_load_q <= 1'b0;
      if (!i2c_on || stop_w) begin
        state_q <= ST_IDLE;
        want_rel_q <= 1'b1;
        done_q <= 1'b0;
      end else if (start_w) begin
        // Repeated start restarts address phase from any state
        state_q <= ST_ADDR;
        bit_cnt_q <= 3'h0;
        want_rel_q <= 1'b1;
        done_q <= 1'b0;
      end else begin
        case (state_q)
          ST_ADDR, ST_WRITE: begin
            if (scl_rise) begin
              shift_q <= shift_in;
              bit_cnt_q <= bit_cnt_q + 3'h1;
              done_q <= bit_cnt_q == 3'h7;
            end else if (scl_fall && done_q) begin
              done_q <= 1'b0;
              if (state_q == ST_WRITE) begin
                rx_data_q <= shift_q;
                rx_valid_q <= 1'b1;
                want_rel_q <= 1'b0;
                state_q <= ST_WRITE_ACK;
              end else if (addr_match) begin
                rw_q <= shift_q[0];
                want_rel_q <= 1'b0;
                state_q <= ST_ADDR_ACK;
              end else begin
                state_q <= ST_WAIT_STOP;
              end
            end
          end
          ST_ADDR_ACK, ST_WRITE_ACK: begin
            if (scl_fall) begin
              bit_cnt_q <= 3'h0;
              if (rw_q) begin
                shift_q <= tx_data_i;
                tx_load_q <= 1'b1;
                want_rel_q <= tx_data_i[7];
                state_q <= ST_READ;
              end else begin
                want_rel_q <= 1'b1;
                state_q <= ST_WRITE;
              end
            end
          end
          ST_READ: begin
            if (scl_fall) begin
              if (bit_cnt_q == 3'h7) begin
                want_rel_q <= 1'b1;
                state_q <= ST_READ_ACK;
              end else begin
                shift_q <= {shift_q[6:0], 1'b0};
                want_rel_q <= shift_q[6];
                bit_cnt_q <= bit_cnt_q + 3'h1;
              end
            end
          end
          ST_READ_ACK: begin
            if (scl_rise) begin
              // A not-acknowledge ends our part of the transfer
              if (sda_f) begin
                state_q <= ST_WAIT_STOP;
              end else begin
                done_q <= 1'b1;
              end
            end else if (scl_fall && done_q) begin
              done_q <= 1'b0;
              bit_cnt_q <= 3'h0;
              shift_q <= tx_data_i;
              tx_load_q <= 1'b1;
              want_rel_q <= tx_data_i[7];
              state_q <= ST_READ;
            end
          end
          ST_IDLE, ST_WAIT_STOP: begin
            want_rel_q <= 1'b1;
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Data hold delay
  // ------------------------------------------------------------
  // Pull-up edges are slow, so driven zeros get their own delay.
  logic drive_low_q;
  logic [6:0] hold_cnt_q;
  wire [3:0] hold_units = want_rel_q ? hold_high : hold_low;
  wire [6:0] hold_target = 7'({3'h0, hold_units} * `HOLD_UNIT_CYCLES);
  wire line_matches = drive_low_q != want_rel_q;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      drive_low_q <= 1'b0;
      hold_cnt_q <= 7'h00;
    end else if (line_matches) begin
      hold_cnt_q <= 7'h00;
    end else if (hold_cnt_q >= hold_target) begin
      drive_low_q <= !want_rel_q;
      hold_cnt_q <= 7'h00;
    end else begin
      hold_cnt_q <= hold_cnt_q + 7'h01;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign sda_o = 1'b0;
  assign sda_oe_o = drive_low_q;
  assign rx_data_o = rx_data_q;
  assign rx_valid_o = rx_valid_q;
  assign tx_load_o = tx_load_q;
  assign spi_cfg_o = cfg_q[`IDX_SPI];
  assign addr_size_o = cfg_q[`IDX_GLOBAL][`ADDR_SIZE_BIT];
  assign crc_en_o = cfg_q[`IDX_GLOBAL][`CRC_EN_BIT];
  assign pad_scl_cfg_o = cfg_q[`IDX_PAD_SCL];
  assign pad_sda_cfg_o = cfg_q[`IDX_PAD_SDA];
  assign pad_sdo_cfg_o = cfg_q[`IDX_PAD_SDO];
  assign pad_ncs_cfg_o = cfg_q[`IDX_PAD_NCS];

endmodule // i2c_target_front_end
`default_nettype wire

//--- hdl/ssi_params.svh
// Constants for the serial target port front end: map, fields, resets
`ifndef SSI_PARAMS_SVH
`define SSI_PARAMS_SVH

// ------------------------------------------------------------
// Register map (printed offsets are word indices)
// ------------------------------------------------------------
`define SSI_BASE_ADDR 32'h0000_0050
`define IDX_FLTR 4'h0
`define IDX_TIMING 4'h1
`define IDX_ADDR 4'h2
`define IDX_SPI 4'h3
`define IDX_GLOBAL 4'h4
`define IDX_PAD_SCL 4'h5
`define IDX_PAD_SDA 4'h6
`define IDX_PAD_SDO 4'h7
`define IDX_PAD_NCS 4'h8
`define IDX_EVENT 4'h9
`define IDX_CRC 4'hA
`define IDX_LOW_SEL 4'hB
`define NUM_CFG 9
`define LAST_CFG 4'h8

// ------------------------------------------------------------
// Reset values and writable masks
// ------------------------------------------------------------
`define RST_FLTR 8'h03
`define RST_TIMING 8'h11
`define RST_ADDR 8'h09
`define RST_SPI 8'h00
`define RST_GLOBAL 8'h06
`define RST_PAD_SCL 8'h16
`define RST_PAD_OTHER 8'h00
`define RST_LOW_SEL 3'h1
`define MASK_FLTR 8'h0F
`define MASK_TIMING 8'hFF
`define MASK_ADDR 8'h7F
`define MASK_SPI 8'h0B
`define MASK_GLOBAL 8'h0F
`define MASK_PAD_SCL 8'h07
`define MASK_PAD_OTHER 8'hFF

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define FLTR_LEN_MSB 3
`define FLTR_LEN_LSB 0
`define HOLD_HIGH_MSB 7
`define HOLD_HIGH_LSB 4
`define HOLD_LOW_MSB 3
`define HOLD_LOW_LSB 0
`define ADDR_UPPER_MSB 6
`define ADDR_UPPER_LSB 3
`define MODE_MSB 1
`define MODE_LSB 0
`define ADDR_SIZE_BIT 2
`define CRC_EN_BIT 3
`define MODE_I2C 2'h1

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define HOLD_UNIT_NS 67
`define HOLD_UNIT_CYCLES 7'h06

`endif

//--- hdl/ssi_pkg.sv
// Types shared by the serial target port front end
`default_nettype none
package ssi_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WRITE,
    ST_WRITE_ACK,
    ST_READ,
    ST_READ_ACK,
    ST_WAIT_STOP
  } i2c_state_t;
endpackage
`default_nettype wire

//--- sim/i2c_host_model.sv
// Behavioural I2C bus host driving the front end's clock and data lines
`default_nettype none
module i2c_host_model (
  input wire logic core_clk_i,
  input wire logic sda_oe_i,
  input wire logic sda_drv_i,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import ssi_pkg::*;
  // Half bit time; longer than the hold delays this bench programs plus filtering
  localparam int H = 40;
  logic sda_h = 1'b1;
  logic smp;
  initial scl_o = 1'b1;
  // Pull-up: the line is low while either side pulls it
  assign sda_o = sda_h & ~(sda_oe_i & ~sda_drv_i);

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  task automatic bitw(input logic b, input logic g);
    sda_h <= b;
    wt(H);
    scl_o <= 1'b1;
    wt(H);
    if (g) begin
      scl_o <= 1'b0;
      wt(2);
      scl_o <= 1'b1;
      wt(H);
    end
    smp = sda_o;
    scl_o <= 1'b0;
    // Data moves a few cycles after the fall, never on it
    wt(4);
  endtask

  task automatic start;
    sda_h <= 1'b1;
    scl_o <= 1'b1;
    wt(H);
    sda_h <= 1'b0;
    wt(H);
    scl_o <= 1'b0;
    wt(4);
  endtask

  task automatic stop;
    sda_h <= 1'b0;
    wt(H);
    scl_o <= 1'b1;
    wt(H);
    sda_h <= 1'b1;
    wt(H);
  endtask

  task automatic xbyte(input byte_t d, input logic g, output logic ack);
    for (int i = 7; i >= 0; i--) bitw(d[i], g && i == 4);
    bitw(1'b1, 1'b0);
    ack = ~smp;
  endtask

  task automatic rbyte(input logic nack, output byte_t d);
    for (int i = 7; i >= 0; i--) begin
      bitw(1'b1, 1'b0);
      d[i] = smp;
    end
    bitw(nack, 1'b0);
  endtask
endmodule // i2c_host_model
`default_nettype wire

//--- sim/i2c_target_front_end_assertions.sv
// Checker for the I2C target front end, bound to its ports
`default_nettype none
`include "ssi_params.svh"
module i2c_target_front_end_assertions (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic scl_i,
  input wire logic sda_oe_o,
  input wire logic rx_valid_o
);
  logic [7:0] flt_q, tim_q, adr_q, glb_q, cnt_q;
  logic scl_q;
  wire acc = psel_i & penable_i;
  wire wr = acc & pwrite_i & pready_o;
  // Addresses below base wrap high and fall out of the map
  wire [31:0] ofs = paddr_i - `SSI_BASE_ADDR;
  wire mapped = ofs <= 32'h0000_002C && ofs[1:0] == 2'h0;
  wire [7:0] exp_rd = ofs == 32'h0 ? flt_q : ofs == 32'h4 ? tim_q :
    ofs == 32'h8 ? adr_q : glb_q;
  wire rd_chk = psel_i & ~penable_i & ~pwrite_i &
    (ofs == 32'h0 | ofs == 32'h4 | ofs == 32'h8 | ofs == 32'h10);
  wire [7:0] lo = tim_q[3:0] * `HOLD_UNIT_CYCLES + 8'h1;
  wire [7:0] hi = tim_q[7:4] * `HOLD_UNIT_CYCLES + 8'h1;
  wire i2c_on = glb_q[1:0] == `MODE_I2C;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      flt_q <= `RST_FLTR;
      tim_q <= `RST_TIMING;
      adr_q <= `RST_ADDR;
      glb_q <= `RST_GLOBAL;
    end else if (wr) begin
      if (ofs == 32'h0) flt_q <= pwdata_i[7:0] & `MASK_FLTR;
      if (ofs == 32'h4) tim_q <= pwdata_i[7:0];
      if (ofs == 32'h8) adr_q <= pwdata_i[7:0] & `MASK_ADDR;
      if (ofs == 32'h10) glb_q <= pwdata_i[7:0] & `MASK_GLOBAL;
    end
  end

  // Cycles since the raw clock input last fell, saturating
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      scl_q <= 1'b1;
      cnt_q <= 8'hFF;
    end else begin
      scl_q <= scl_i;
      cnt_q <= (scl_q & ~scl_i) ? 8'h0 : cnt_q + {7'h0, cnt_q != 8'hFF};
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  property p_ready; acc |-> pready_o; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err; acc & ~mapped |-> pslverr_o; endproperty
  a_err: assert property (p_err) else $error("no slave error");
  property p_ok; acc & mapped |-> !pslverr_o; endproperty
  a_ok: assert property (p_ok) else $error("bad slave error");
  property p_rd; rd_chk |=> prdata_o == {24'h00_0000, exp_rd}; endproperty
  a_rd: assert property (p_rd) else $error("read data");
  property p_idle; (!i2c_on) [*8] |-> !sda_oe_o; endproperty
  a_idle: assert property (p_idle) else $error("drives off mode");
  property p_low;
    $rose(sda_oe_o) |-> cnt_q >= lo && cnt_q <= lo + flt_q + 8'h5;
  endproperty
  a_low: assert property (p_low) else $error("low hold");
  property p_high;
    $fell(sda_oe_o) && i2c_on |-> cnt_q >= hi && cnt_q <= hi + flt_q + 8'h5;
  endproperty
  a_high: assert property (p_high) else $error("high hold");
  property p_rx; rx_valid_o |-> i2c_on ##1 !rx_valid_o; endproperty
  a_rx: assert property (p_rx) else $error("rx pulse");
endmodule // i2c_target_front_end_assertions
bind i2c_target_front_end i2c_target_front_end_assertions chk (.*);
`default_nettype wire

//--- sim/tb_i2c_target_front_end.sv
// Self-checking bench for the I2C target front end
`default_nettype none
`include "ssi_params.svh"
module tb_i2c_target_front_end;
  timeunit 1ns;
  timeprecision 1ns;
  import ssi_pkg::*;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [31:0] paddr_i = 32'h0000_0000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o, scl, sda, sda_o, sda_oe_o, rx_valid_o;
  wire byte_t rx_data_o;
  wire addr_size, crc_en, tx_load;
  wire byte_t spi_cfg, pad_scl, pad_sda, pad_sdo, pad_ncs;
  byte_t tx_data_i = 8'h5A;
  byte_t rx_seen = 8'h00;
  int err_count = 0;
  int checks_done = 0;
  int loads = 0;

  i2c_target_front_end uut (.core_clk_i, .reset_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe_o, .rx_data_o, .rx_valid_o,
    .tx_data_i, .tx_load_o(tx_load), .spi_cfg_o(spi_cfg),
    .addr_size_o(addr_size), .crc_en_o(crc_en), .pad_scl_cfg_o(pad_scl),
    .pad_sda_cfg_o(pad_sda), .pad_sdo_cfg_o(pad_sdo),
    .pad_ncs_cfg_o(pad_ncs));
  i2c_host_model host (.core_clk_i, .sda_oe_i(sda_oe_o), .sda_drv_i(sda_o),
    .scl_o(scl), .sda_o(sda));

  initial forever #10 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (rx_valid_o === 1'b1) rx_seen <= rx_data_o;
  always @(posedge core_clk_i) if (tx_load === 1'b1) loads <= loads + 1;

  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_b(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: bit got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [3:0] i,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= `SSI_BASE_ADDR + 32'(i) * 32'h4;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do @(posedge core_clk_i); while (pready_o !== 1'b1 && ++n < 16);
    if (n >= 16) begin
      err_count++;
      $display("ERROR %0t: pready timeout", $time);
      close_out;
    end
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge core_clk_i);
  endtask

  task automatic wr(input logic [3:0] i, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, i, d, q, e);
  endtask

  task automatic rdc(input logic [3:0] i, input logic [31:0] x,
    input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, i, 32'h0000_0000, q, e);
    chk_w(q, x);
    chk_b(e, xe);
  endtask

  task automatic i2c_try(input byte_t a, input logic g, input logic x);
    logic ack;
    host.start;
    host.xbyte(a, g, ack);
    chk_b(ack, x);
    host.stop;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rdc(`IDX_FLTR, 32'h0000_0003, 1'b0);
    rdc(`IDX_TIMING, 32'h0000_0011, 1'b0);
    rdc(`IDX_ADDR, 32'h0000_0009, 1'b0);
    rdc(`IDX_GLOBAL, 32'h0000_0006, 1'b0);
    rdc(4'hC, 32'h0000_0000, 1'b1);
    wr(`IDX_FLTR, 32'h0000_00FF);
    rdc(`IDX_FLTR, 32'h0000_000F, 1'b0);
    wr(`IDX_FLTR, 32'h0000_0003);
  endtask

  task automatic t_cfg;
    rdc(`IDX_SPI, 32'h0000_0000, 1'b0);
    rdc(`IDX_PAD_SCL, 32'h0000_0016, 1'b0);
    rdc(`IDX_EVENT, 32'h0000_0000, 1'b0);
    rdc(`IDX_CRC, 32'h0000_0000, 1'b0);
    chk_b(addr_size, 1'b1);
    chk_b(crc_en, 1'b0);
    wr(`IDX_SPI, 32'h0000_00FF);
    wr(`IDX_PAD_SCL, 32'h0000_00FF);
    wr(`IDX_PAD_SDA, 32'h0000_00A5);
    wr(`IDX_PAD_SDO, 32'h0000_003C);
    wr(`IDX_PAD_NCS, 32'h0000_00C3);
    wr(`IDX_EVENT, 32'h0000_00FF);
    wr(`IDX_GLOBAL, 32'h0000_0008);
    rdc(`IDX_SPI, 32'h0000_000B, 1'b0);
    rdc(`IDX_PAD_SCL, 32'h0000_0017, 1'b0);
    rdc(`IDX_EVENT, 32'h0000_0000, 1'b0);
    chk_w(32'(spi_cfg), 32'h0000_000B);
    chk_w(32'(pad_scl), 32'h0000_0017);
    chk_w({pad_sda, pad_sdo, pad_ncs, 8'h00}, 32'hA53C_C300);
    chk_b(addr_size, 1'b0);
    chk_b(crc_en, 1'b1);
    wr(`IDX_GLOBAL, 32'h0000_0006);
  endtask

  task automatic t_addr;
    logic ack;
    i2c_try(8'h12, 1'b0, 1'b0);
    wr(`IDX_GLOBAL, 32'h0000_0005);
    host.start;
    host.xbyte(8'h12, 1'b0, ack);
    chk_b(ack, 1'b1);
    host.xbyte(8'hA5, 1'b0, ack);
    chk_b(ack, 1'b1);
    host.stop;
    chk_w(32'(rx_seen), 32'h0000_00A5);
    i2c_try(8'h14, 1'b0, 1'b0);
    wr(`IDX_GLOBAL, 32'h0000_0004);
    i2c_try(8'h12, 1'b0, 1'b0);
    wr(`IDX_GLOBAL, 32'h0000_0005);
  endtask

  task automatic t_lowsel;
    wr(`IDX_LOW_SEL, 32'h0000_0003);
    rdc(`IDX_LOW_SEL, 32'h0000_0003, 1'b0);
    i2c_try(8'h16, 1'b0, 1'b1);
    i2c_try(8'h12, 1'b0, 1'b0);
    wr(`IDX_LOW_SEL, 32'h0000_0001);
    wr(`IDX_ADDR, 32'h0000_00A8);
    rdc(`IDX_ADDR, 32'h0000_0028, 1'b0);
    i2c_try(8'h52, 1'b0, 1'b1);
    i2c_try(8'h12, 1'b0, 1'b0);
    wr(`IDX_ADDR, 32'h0000_0009);
  endtask

  task automatic t_hold;
    logic ack;
    byte_t d;
    int n0;
    wr(`IDX_TIMING, 32'h0000_0032);
    n0 = loads;
    host.start;
    host.xbyte(8'h13, 1'b0, ack);
    chk_b(ack, 1'b1);
    host.rbyte(1'b1, d);
    chk_w(32'(d), 32'h0000_005A);
    host.stop;
    chk_w(32'(loads - n0), 32'h0000_0001);
  endtask

  task automatic t_glitch;
    i2c_try(8'h12, 1'b1, 1'b1);
    wr(`IDX_FLTR, 32'h0000_0000);
    i2c_try(8'h12, 1'b1, 1'b0);
    wr(`IDX_FLTR, 32'h0000_0003);
  endtask

  initial begin
    repeat (5) @(posedge core_clk_i);
    reset_i <= 1'b0;
    @(posedge core_clk_i);
    t_regs;
    t_cfg;
    t_addr;
    t_lowsel;
    t_hold;
    t_glitch;
    close_out;
  end
endmodule // tb_i2c_target_front_end
`default_nettype wire
